// [test_ulf_channel.sv]
// Self-checking bench for the channel control block.
module test_ulf_channel import ulf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic gate = 1'b1;
  logic tx_push = 1'b0, tx_pop = 1'b0, rx_push = 1'b0, rx_pop = 1'b0;
  logic rx_char_valid = 1'b0, rx_char_is_flow = 1'b0, soft_flow_active = 1'b0;
  logic tx_halted = 1'b0;
  logic tx_raw = 1'b1, ir_raw = 1'b0;
  logic rx_request_pin_n_q, ring_loop_q, resume_tx_q;
  logic serial_in, ir_in;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, serial_out_q, ir_out_q, terminal_ready_n_q, request_send_n_q;
  logic spare_output_one_n_q, spare_output_two_n_q, int_out_oe_n_q, tx_request_pin_n_q;
  logic tx_int_q, rx_int_q, divisor_select_q, parity_en_q, parity_fixed_q, parity_value_q;
  logic parity_even_q, loopback_q, rx_line_q, rx_store_q, baud_tick_q;
  logic [3:0] data_bits_q;
  logic [2:0] stop_halfbits_q;
  int fail_count = 0;
  int samples_checked = 0;
  always #20 sys_clk = ~sys_clk;

  ulf_channel u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .enhanced_feature_gate(gate), .tx_push(tx_push),
    .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop), .rx_char_valid(rx_char_valid),
    .rx_char_is_flow(rx_char_is_flow), .soft_flow_active(soft_flow_active),
    .tx_halted(tx_halted), .serial_in(serial_in), .ir_in(ir_in), .tx_serial_raw(tx_raw),
    .ir_tx_raw(ir_raw), .serial_out_q(serial_out_q), .ir_out_q(ir_out_q),
    .terminal_ready_n_q(terminal_ready_n_q), .request_send_n_q(request_send_n_q),
    .spare_output_one_n_q(spare_output_one_n_q), .spare_output_two_n_q(spare_output_two_n_q),
    .int_out_oe_n_q(int_out_oe_n_q), .tx_request_pin_n_q(tx_request_pin_n_q),
    .rx_request_pin_n_q(rx_request_pin_n_q), .tx_int_q(tx_int_q), .rx_int_q(rx_int_q),
    .divisor_select_q(divisor_select_q), .data_bits_q(data_bits_q),
    .stop_halfbits_q(stop_halfbits_q), .parity_en_q(parity_en_q),
    .parity_fixed_q(parity_fixed_q), .parity_value_q(parity_value_q),
    .parity_even_q(parity_even_q), .loopback_q(loopback_q), .ring_loop_q(ring_loop_q),
    .rx_line_q(rx_line_q), .resume_tx_q(resume_tx_q), .rx_store_q(rx_store_q),
    .baud_tick_q(baud_tick_q));
  ulf_line_partner u_line (.sys_clk(sys_clk), .serial_out_q(serial_out_q),
    .serial_in(serial_in), .ir_in(ir_in));

  // ****************
  // Shared tasks
  // ****************
  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access; the request holds until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    settle();
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  // Outputs from the occupancy counter lag by two edges, so three are allowed.
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Pulses one event line for n cycles: 0 tx push, 1 tx pop, 2 rx push.
  task automatic strobe(input int k, input int n);
    @(posedge sys_clk);
    {rx_pop, rx_push, tx_pop, tx_push} <= 4'h1 << k;
    repeat (n) @(posedge sys_clk);
    {rx_pop, rx_push, tx_pop, tx_push} <= 4'h0;
    settle();
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_format();
    for (int c = 0; c < 4; c++) begin
      wr(ULF_OFF_LINE_FORMAT, 8'h04 | c);
      check(data_bits_q, 5 + c);
      check(stop_halfbits_q, (c == 0) ? ULF_STOP_ONE_HALF : ULF_STOP_TWO);
    end
    for (int p = 0; p < 4; p++) begin
      wr(ULF_OFF_LINE_FORMAT, 8'h08 | (p << 4));
      check(parity_en_q, 1'b1);
      check(parity_fixed_q, p[1]);
      check(parity_value_q, !p[0]);
      if (p < 2) check(parity_even_q, p[0]);
    end
    wr(ULF_OFF_LINE_FORMAT, 8'h40);
    check(serial_out_q, 1'b0);
    wr(ULF_OFF_LINE_FORMAT, 8'h80);
    check(serial_out_q, 1'b1);
    check(divisor_select_q, 1'b1);
    rd(ULF_OFF_LINE_FORMAT, 32'h80);
    $display("format test done");
  endtask
  task automatic t_modem();
    @(posedge sys_clk);
    gate <= 1'b0;
    wr(ULF_OFF_LINE_OUTPUTS, 8'hFF);
    rd(ULF_OFF_LINE_OUTPUTS, 32'h1F);
    check({terminal_ready_n_q, request_send_n_q}, 2'b00);
    check({spare_output_two_n_q, int_out_oe_n_q}, 2'b00);
    check({loopback_q, ir_out_q}, 2'b10);
    check({ring_loop_q, spare_output_one_n_q}, 2'b10);
    // A space from the transmitter must come back inside, not on the pin.
    @(posedge sys_clk);
    tx_raw <= 1'b0;
    settle();
    check({rx_line_q, serial_out_q}, 2'b01);
    @(posedge sys_clk);
    tx_raw <= 1'b1;
    gate <= 1'b1;
    wr(ULF_OFF_LINE_OUTPUTS, 8'h40);
    check({terminal_ready_n_q, spare_output_two_n_q}, 2'b11);
    check({ir_out_q, rx_line_q}, 2'b01);
    @(posedge sys_clk);
    ir_raw <= 1'b1;
    settle();
    check({ir_out_q, serial_out_q}, 2'b11);
    @(posedge sys_clk);
    ir_raw <= 1'b0;
    wr(ULF_OFF_LINE_OUTPUTS, 8'h44);
    check({rx_line_q, ring_loop_q}, 2'b00);
    wr(ULF_OFF_LINE_OUTPUTS, 8'h20);
    @(posedge sys_clk);
    {rx_char_valid, tx_halted, rx_char_is_flow, soft_flow_active} <= 4'hF;
    settle();
    check({rx_store_q, resume_tx_q}, 2'b01);
    @(posedge sys_clk);
    soft_flow_active <= 1'b0;
    settle();
    check(rx_store_q, 1'b1);
    $display("modem test done");
  endtask
  task automatic t_fifo();
    wr(ULF_OFF_FIFO_SETUP, 8'h01);
    strobe(2, 1);
    check(rx_int_q, 1'b1);
    check(rx_request_pin_n_q, 1'b0);
    rd(ULF_OFF_LINE_CONDITION, 32'h1);
    wr(ULF_OFF_FIFO_SETUP, 8'h43);
    strobe(2, 15);
    check(rx_int_q, 1'b0);
    strobe(2, 1);
    check(rx_int_q, 1'b1);
    wr(ULF_OFF_FIFO_SETUP, 8'h15);
    check(tx_int_q, 1'b1);
    strobe(0, 9);
    check(tx_int_q, 1'b0);
    strobe(1, 2);
    check(tx_int_q, 1'b1);
    check(tx_request_pin_n_q, 1'b1);
    wr(ULF_OFF_FIFO_SETUP, 8'h09);
    check(tx_request_pin_n_q, 1'b0);
    // The transmit clear bit without the enable must not act; the count stays put.
    wr(ULF_OFF_FIFO_SETUP, 8'h0C);
    check(tx_request_pin_n_q, 1'b1);
    wr(ULF_OFF_FIFO_SETUP, 8'h05);
    check({tx_request_pin_n_q, tx_int_q}, 2'b01);
    $display("fifo test done");
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle();
    check({data_bits_q, stop_halfbits_q, parity_value_q}, {4'h5, ULF_STOP_ONE, 1'b1});
    check({serial_out_q, terminal_ready_n_q, spare_output_two_n_q, rx_request_pin_n_q}, 4'hF);
    rd(ULF_OFF_LINE_OUTPUTS, 32'h0);
    rd(4'h2, 32'h0);
    t_format();
    t_modem();
    t_fifo();
    wr(ULF_OFF_LINE_OUTPUTS, 8'h80);
    repeat (12) @(posedge sys_clk);
    rd(ULF_OFF_LINE_OUTPUTS, 32'h80);
    tally_and_finish();
  end
endmodule

// [ulf_channel.sv]
// Per-channel UART line format, FIFO setup and modem output control block.
module ulf_channel
  import ulf_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic enhanced_feature_gate,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic rx_char_valid,
  input wire logic rx_char_is_flow,
  input wire logic soft_flow_active,
  input wire logic tx_halted,
  input wire logic serial_in,
  input wire logic ir_in,
  input wire logic tx_serial_raw,
  input wire logic ir_tx_raw,
  output logic serial_out_q,
  output logic ir_out_q,
  output logic terminal_ready_n_q,
  output logic request_send_n_q,
  output logic spare_output_one_n_q,
  output logic spare_output_two_n_q,
  output logic int_out_oe_n_q,
  output logic tx_request_pin_n_q,
  output logic rx_request_pin_n_q,
  output logic tx_int_q,
  output logic rx_int_q,
  output logic divisor_select_q,
  output logic [3:0] data_bits_q,
  output logic [2:0] stop_halfbits_q,
  output logic parity_en_q,
  output logic parity_fixed_q,
  output logic parity_value_q,
  output logic parity_even_q,
  output logic loopback_q,
  output logic ring_loop_q,
  output logic rx_line_q,
  output logic resume_tx_q,
  output logic rx_store_q,
  output logic baud_tick_q
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (FIFO_DEPTH != 32) begin : g_bad_depth
    $error("ulf_channel: trigger table assumes a 32-entry FIFO");
  end

  // ************************************************************
  // Decode functions
  // ************************************************************

  // Transmit trigger by code.
  function automatic logic [5:0] tx_level(input logic [1:0] code);
    logic [5:0] r;
    r = ULF_TX_TRIG_00;
    unique case (code)
      2'h0: r = ULF_TX_TRIG_00;
      2'h1: r = ULF_TX_TRIG_01;
      2'h2: r = ULF_TX_TRIG_10;
      2'h3: r = ULF_TX_TRIG_11;
    endcase
    return r;
  endfunction

  // Receive trigger by code.
  function automatic logic [5:0] rx_level(input logic [1:0] code);
    logic [5:0] r;
    r = ULF_RX_TRIG_00;
    unique case (code)
      2'h0: r = ULF_RX_TRIG_00;
      2'h1: r = ULF_RX_TRIG_01;
      2'h2: r = ULF_RX_TRIG_10;
      2'h3: r = ULF_RX_TRIG_11;
    endcase
    return r;
  endfunction

  // ************************************************************
  // Bus slave
  // ************************************************************

  // Every access takes three cycles: taken in IDLE, written in BUSY, answered in DONE.
  ulf_bus_e state_q;
  ulf_bus_e state_d;
  wire logic req = avs_read || avs_write;
  wire logic hit_fifo = (avs_address == ULF_OFF_FIFO_SETUP);
  wire logic hit_format = (avs_address == ULF_OFF_LINE_FORMAT);
  wire logic hit_outputs = (avs_address == ULF_OFF_LINE_OUTPUTS);
  wire logic hit_cond = (avs_address == ULF_OFF_LINE_CONDITION);
  wire logic fire = (state_q == ULF_BUSY);
  wire logic wr_lane = fire && avs_write && avs_byteenable[0];
  wire logic [7:0] wbyte = avs_writedata[7:0];

  // Access sequencer.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ULF_IDLE: state_d = req ? ULF_BUSY : ULF_IDLE;
      ULF_BUSY: state_d = ULF_DONE;
      ULF_DONE: state_d = ULF_IDLE;
      default: state_d = ULF_IDLE;
    endcase
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [7:0] fifo_setup_q;
  logic [7:0] line_format_q;
  logic [7:0] line_outputs_control_q;
  logic fifo_on_q;
  logic [5:0] tx_trig_q;
  logic [5:0] rx_trig_q;

  // Only fifo_on_q takes every write; the other fields count only when the enable bit rides along.
  // enable in same write
  wire logic fs_write = wr_lane && hit_fifo && wbyte[ULF_FS_ENABLE];
  wire logic tx_clear = fs_write && wbyte[ULF_FS_TX_CLR];
  wire logic rx_clear = fs_write && wbyte[ULF_FS_RX_CLR];
  // Transmit trigger field only lands while the enhanced gate is open.
  // enhanced gate
  wire logic [1:0] tx_code = enhanced_feature_gate ?
    wbyte[ULF_FS_TXTRIG_LO +: 2] : fifo_setup_q[ULF_FS_TXTRIG_LO +: 2];
  wire logic [1:0] rx_code = wbyte[ULF_FS_RXTRIG_LO +: 2];
  // Enhanced-only bits of line_outputs_control keep their value when gated.
  wire logic [7:0] lo_mask = enhanced_feature_gate ? 8'hFF : 8'h1F;
  wire logic [7:0] lo_next = (wbyte & lo_mask) | (line_outputs_control_q & ~lo_mask);

  // Register file update; the clear bits never stay stored.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ULF_IDLE;
      fifo_setup_q <= ULF_RST_BYTE;
      line_format_q <= ULF_RST_BYTE;
      line_outputs_control_q <= ULF_RST_BYTE;
      fifo_on_q <= 1'b0;
      tx_trig_q <= ULF_TRIG_DEFAULT;
      rx_trig_q <= ULF_TRIG_DEFAULT;
    end else begin
      state_q <= state_d;
      if (wr_lane && hit_fifo) begin
        fifo_on_q <= wbyte[ULF_FS_ENABLE];
      end
      if (fs_write) begin
        fifo_setup_q <= {rx_code, tx_code, wbyte[ULF_FS_DMA], 2'h0, 1'b1};
        tx_trig_q <= (tx_code == 2'h0) ? rx_level(rx_code) : tx_level(tx_code);
        rx_trig_q <= (rx_code == 2'h0) ? tx_level(tx_code) : rx_level(rx_code);
        if (tx_code == 2'h0 && rx_code == 2'h0) begin
          tx_trig_q <= ULF_TRIG_DEFAULT;
          rx_trig_q <= ULF_TRIG_DEFAULT;
        end
      end
      if (wr_lane && hit_format) begin
        line_format_q <= wbyte;
      end
      if (wr_lane && hit_outputs) begin
        line_outputs_control_q <= lo_next;
      end
    end
  end

  // ************************************************************
  // FIFO occupancy and triggers
  // ************************************************************
  logic [5:0] tx_count;
  logic [5:0] rx_count;
  logic tx_flag;
  logic rx_flag;
  // Receive FIFO store decision for software flow control.
  // flow characters dropped
  wire logic rx_store_d = !(rx_char_is_flow && soft_flow_active);

  ulf_fifo_level #(.DEPTH(FIFO_DEPTH)) u_tx_level (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(tx_clear),
    .push(tx_push),
    .pop(tx_pop),
    .is_tx(1'b1),
    .trigger(tx_trig_q),
    .level_q(tx_count),
    .flag_q(tx_flag)
  );

  ulf_fifo_level #(.DEPTH(FIFO_DEPTH)) u_rx_level (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(rx_clear),
    .push(rx_push && rx_store_d),
    .pop(rx_pop),
    .is_tx(1'b0),
    .trigger(rx_trig_q),
    .level_q(rx_count),
    .flag_q(rx_flag)
  );

  // ************************************************************
  // Derived line controls
  // ************************************************************
  wire logic [1:0] len_code = line_format_q[ULF_LF_LEN_LO +: 2];
  wire logic stop_long = line_format_q[ULF_LF_STOP];
  wire logic par_even = line_format_q[ULF_LF_PAR_EVEN];
  wire logic ir_mode = line_outputs_control_q[ULF_LO_IR_EN];
  wire logic loop_mode = line_outputs_control_q[ULF_LO_LOOP];
  wire logic dma_mode = fifo_setup_q[ULF_FS_DMA] && fifo_on_q;
  wire logic [3:0] bits_d = ULF_LEN_BASE + {2'h0, len_code};
  wire logic [2:0] stop_d = !stop_long ? ULF_STOP_ONE :
    (len_code == 2'h0) ? ULF_STOP_ONE_HALF : ULF_STOP_TWO;
  // request pin modes; normal mode frees the transmit pin and asserts the receive pin as soon as data moves.
  wire logic tx_req_d = dma_mode ? (tx_count == ULF_FIFO_DEPTH) : (tx_count != ULF_CNT_ZERO);
  wire logic rx_req_d = dma_mode ? !rx_flag : (rx_count == ULF_CNT_ZERO);
  wire logic ir_decoded = ir_in ^ ~line_outputs_control_q[ULF_LO_IR_POL];
  wire logic tx_line_d = line_format_q[ULF_LF_BREAK] ? 1'b0 : tx_serial_raw;
  wire logic rx_line_d = loop_mode ? tx_line_d : (ir_mode ? ir_decoded : serial_in);
  // Loopback keeps the outside line at mark.
  wire logic serial_d = loop_mode ? 1'b1 : (ir_mode ? 1'b1 : tx_line_d);
  wire logic ir_d = (ir_mode && !loop_mode) ? (ir_tx_raw && tx_line_d) : 1'b0;
  wire logic [7:0] cond_byte = {7'h00, rx_count != ULF_CNT_ZERO};
  logic [1:0] pre_q;

  // Line pins and decoded format, all registered.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      serial_out_q <= 1'b1;
      ir_out_q <= 1'b0;
      terminal_ready_n_q <= 1'b1;
      request_send_n_q <= 1'b1;
      spare_output_one_n_q <= 1'b1;
      spare_output_two_n_q <= 1'b1;
      int_out_oe_n_q <= 1'b1;
      tx_request_pin_n_q <= 1'b0;
      rx_request_pin_n_q <= 1'b1;
      tx_int_q <= 1'b0;
      rx_int_q <= 1'b0;
      divisor_select_q <= 1'b0;
      data_bits_q <= ULF_LEN_BASE;
      stop_halfbits_q <= ULF_STOP_ONE;
      parity_en_q <= 1'b0;
      parity_fixed_q <= 1'b0;
      parity_value_q <= 1'b1;
      parity_even_q <= 1'b0;
      loopback_q <= 1'b0;
      ring_loop_q <= 1'b0;
      rx_line_q <= 1'b1;
      resume_tx_q <= 1'b0;
      rx_store_q <= 1'b1;
      baud_tick_q <= 1'b0;
      pre_q <= 2'h0;
    end else begin
      serial_out_q <= serial_d;
      ir_out_q <= ir_d;
      terminal_ready_n_q <= ~line_outputs_control_q[ULF_LO_TERM_RDY];
      request_send_n_q <= ~line_outputs_control_q[ULF_LO_REQ_SEND];
      spare_output_one_n_q <= ~line_outputs_control_q[ULF_LO_IR_POL];
      spare_output_two_n_q <= ~line_outputs_control_q[ULF_LO_INT_EN];
      int_out_oe_n_q <= ~line_outputs_control_q[ULF_LO_INT_EN];
      tx_request_pin_n_q <= tx_req_d;
      rx_request_pin_n_q <= rx_req_d;
      tx_int_q <= fifo_on_q ? tx_flag : (tx_count == ULF_CNT_ZERO);
      rx_int_q <= rx_flag;
      divisor_select_q <= line_format_q[ULF_LF_DIVISOR];
      data_bits_q <= bits_d;
      stop_halfbits_q <= stop_d;
      parity_en_q <= line_format_q[ULF_LF_PAR_EN];
      parity_fixed_q <= line_format_q[ULF_LF_PAR_FORCE];
      parity_value_q <= ~par_even;
      parity_even_q <= par_even;
      loopback_q <= loop_mode;
      ring_loop_q <= loop_mode && line_outputs_control_q[ULF_LO_IR_POL];
      rx_line_q <= rx_line_d;
      resume_tx_q <= line_outputs_control_q[ULF_LO_ANY_RESUME] && rx_char_valid && tx_halted;
      rx_store_q <= rx_store_d;
      if (!line_outputs_control_q[ULF_LO_PRESCALE]) begin
        pre_q <= 2'h0;
        baud_tick_q <= 1'b1;
      end else begin
        pre_q <= pre_q + 2'h1;
        baud_tick_q <= (pre_q == ULF_PRESCALE_MAX[1:0]);
      end
    end
  end

  // ************************************************************
  // Read data and wait request
  // ************************************************************

  // Unmapped and write-only locations read as zero.
  wire logic [7:0] rbyte = hit_format ? line_format_q :
    hit_outputs ? line_outputs_control_q : hit_cond ? cond_byte : ULF_RST_BYTE;
  wire logic wait_d = !(state_d == ULF_DONE);

  // Answer registers; waitrequest drops for one cycle at DONE.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      avs_readdata <= {24'h000000, rbyte};
      avs_waitrequest <= wait_d;
    end
  end

endmodule

// [ulf_channel_assertions.sv]
// Concurrent checks on the channel ports, bound into the channel.
module ulf_channel_assertions
  import ulf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic serial_out_q,
  input wire logic ir_out_q,
  input wire logic terminal_ready_n_q,
  input wire logic spare_output_two_n_q,
  input wire logic int_out_oe_n_q,
  input wire logic loopback_q,
  input wire logic [3:0] data_bits_q,
  input wire logic [2:0] stop_halfbits_q,
  input wire logic parity_value_q,
  input wire logic baud_tick_q
);
  // ****************
  // Write decode
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // A write counts only at the answering edge, with lane 0 enabled.
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire fmt_wr = wr_ok && (avs_address == ULF_OFF_LINE_FORMAT);
  wire out_wr = wr_ok && (avs_address == ULF_OFF_LINE_OUTPUTS);

  // ****************
  // Properties
  // ****************
  a_bus_answer: assert property ($rose(avs_read) |-> avs_waitrequest ##1 avs_waitrequest
    ##1 !avs_waitrequest) else $error("read answer not on third cycle");
  a_len_write: assert property (fmt_wr |=> data_bits_q == ULF_LEN_BASE + $past(avs_writedata[1:0]))
    else $error("data bits do not follow length code");
  a_stop_pair: assert property (stop_halfbits_q != ULF_STOP_ONE |-> stop_halfbits_q ==
    ((data_bits_q == ULF_LEN_BASE) ? ULF_STOP_ONE_HALF : ULF_STOP_TWO))
    else $error("stop length does not match data bits");
  a_break_low: assert property (fmt_wr && avs_writedata[6] |=> !serial_out_q)
    else $error("break did not pull serial output low");
  a_forced_value: assert property (fmt_wr |=> parity_value_q == !$past(avs_writedata[4]))
    else $error("forced parity value wrong");
  a_ready_invert: assert property (out_wr |=> terminal_ready_n_q == !$past(avs_writedata[0]))
    else $error("terminal ready pin not inverted");
  a_spare_oe: assert property (int_out_oe_n_q == spare_output_two_n_q)
    else $error("interrupt enable and spare output disagree");
  a_ir_quiet: assert property (loopback_q |-> !ir_out_q)
    else $error("infrared output active in loopback");
  a_tick_gap: assert property ($fell(baud_tick_q) |-> !baud_tick_q [*3] ##1 baud_tick_q)
    else $error("prescaled tick not one in four");
endmodule

bind ulf_channel ulf_channel_assertions u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .serial_out_q(serial_out_q), .ir_out_q(ir_out_q),
  .terminal_ready_n_q(terminal_ready_n_q), .spare_output_two_n_q(spare_output_two_n_q),
  .int_out_oe_n_q(int_out_oe_n_q), .loopback_q(loopback_q), .data_bits_q(data_bits_q),
  .stop_halfbits_q(stop_halfbits_q), .parity_value_q(parity_value_q),
  .baud_tick_q(baud_tick_q));

// [ulf_fifo_level.sv]
// Occupancy counter and trigger flag generator for one channel FIFO.
module ulf_fifo_level
  import ulf_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic is_tx,
  input wire logic [5:0] trigger,
  output logic [5:0] level_q,
  output logic flag_q
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (DEPTH < 2 || DEPTH > 63) begin : g_bad_depth
    $error("ulf_fifo_level: DEPTH out of range");
  end

  // Push ignored when full, pop ignored when empty.
  wire logic do_push = push && (level_q != 6'(DEPTH));
  wire logic do_pop = pop && (level_q != ULF_CNT_ZERO);
  logic [5:0] level_d;
  // Remembers whether the last reload lifted the level above the trigger.
  logic filled_q;
  logic filled_d;
  logic flag_d;

  // Next occupancy and trigger flag.
  always_comb begin
    level_d = level_q;
    if (clear) begin
      level_d = ULF_CNT_ZERO;
    end else if (do_push && !do_pop) begin
      level_d = level_q + ULF_CNT_ONE;
    end else if (do_pop && !do_push) begin
      level_d = level_q - ULF_CNT_ONE;
    end
    filled_d = filled_q;
    if (level_d > trigger) begin
      filled_d = 1'b1;
    end else if (level_d == ULF_CNT_ZERO) begin
      filled_d = 1'b0;
    end
    if (is_tx) begin
      flag_d = filled_q ? (level_d < trigger) : (level_d == ULF_CNT_ZERO);
    end else begin
      flag_d = (level_d >= trigger);
    end
  end

  // Occupancy registers.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      level_q <= ULF_CNT_ZERO;
      filled_q <= 1'b0;
      flag_q <= is_tx;
    end else begin
      level_q <= level_d;
      filled_q <= filled_d;
      flag_q <= flag_d;
    end
  end

endmodule

// [ulf_line_partner.sv]
// Model of the remote line equipment facing the channel.
module ulf_line_partner (
  input wire logic sys_clk,
  input wire logic serial_out_q,
  output logic serial_in,
  output logic ir_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The remote sender is idle: a wired line rests at mark.
  assign serial_in = 1'b1;
  // An idle active-high infrared sender keeps its line low.
  assign ir_in = 1'b0;
endmodule

// [ulf_pkg.sv]
// Package for the per-channel UART line, FIFO and modem control block.
package ulf_pkg;

  // ************************************************************
  // Register offsets (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] ULF_OFF_FIFO_SETUP = 4'h0;
  localparam logic [3:0] ULF_OFF_LINE_FORMAT = 4'h4;
  localparam logic [3:0] ULF_OFF_LINE_OUTPUTS = 4'h8;
  localparam logic [3:0] ULF_OFF_LINE_CONDITION = 4'hC;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] ULF_RST_BYTE = 8'h00;
  localparam logic [5:0] ULF_CNT_ZERO = 6'h00;
  localparam logic [5:0] ULF_CNT_ONE = 6'h01;

  // ************************************************************
  // Field positions in fifo_setup
  // ************************************************************
  localparam int ULF_FS_ENABLE = 0;
  localparam int ULF_FS_RX_CLR = 1;
  localparam int ULF_FS_TX_CLR = 2;
  localparam int ULF_FS_DMA = 3;
  localparam int ULF_FS_TXTRIG_LO = 4;
  localparam int ULF_FS_RXTRIG_LO = 6;

  // ************************************************************
  // Field positions in line_format
  // ************************************************************
  localparam int ULF_LF_LEN_LO = 0;
  localparam int ULF_LF_STOP = 2;
  localparam int ULF_LF_PAR_EN = 3;
  localparam int ULF_LF_PAR_EVEN = 4;
  localparam int ULF_LF_PAR_FORCE = 5;
  localparam int ULF_LF_BREAK = 6;
  localparam int ULF_LF_DIVISOR = 7;

  // ************************************************************
  // Field positions in line_outputs_control
  // ************************************************************
  localparam int ULF_LO_TERM_RDY = 0;
  localparam int ULF_LO_REQ_SEND = 1;
  localparam int ULF_LO_IR_POL = 2;
  localparam int ULF_LO_INT_EN = 3;
  localparam int ULF_LO_LOOP = 4;
  localparam int ULF_LO_ANY_RESUME = 5;
  localparam int ULF_LO_IR_EN = 6;
  localparam int ULF_LO_PRESCALE = 7;

  // ************************************************************
  // Trigger levels in characters
  // ************************************************************
  localparam logic [5:0] ULF_TX_TRIG_00 = 6'h10;
  localparam logic [5:0] ULF_TX_TRIG_01 = 6'h08;
  localparam logic [5:0] ULF_TX_TRIG_10 = 6'h18;
  localparam logic [5:0] ULF_TX_TRIG_11 = 6'h1E;
  localparam logic [5:0] ULF_RX_TRIG_00 = 6'h08;
  localparam logic [5:0] ULF_RX_TRIG_01 = 6'h10;
  localparam logic [5:0] ULF_RX_TRIG_10 = 6'h18;
  localparam logic [5:0] ULF_RX_TRIG_11 = 6'h1C;
  localparam logic [5:0] ULF_TRIG_DEFAULT = 6'h01;
  localparam logic [5:0] ULF_FIFO_DEPTH = 6'h20;

  // ************************************************************
  // Character format constants
  // ************************************************************
  localparam logic [3:0] ULF_LEN_BASE = 4'h5;
  // Stop length in half bit times: 2 = one, 3 = one and a half, 4 = two.
  localparam logic [2:0] ULF_STOP_ONE = 3'h2;
  localparam logic [2:0] ULF_STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] ULF_STOP_TWO = 3'h4;
  localparam logic [2:0] ULF_PRESCALE_MAX = 3'h3;

  // Bus access sequencing states.
  typedef enum logic [2:0] {
    ULF_IDLE = 3'b001,
    ULF_BUSY = 3'b010,
    ULF_DONE = 3'b100
  } ulf_bus_e;

endpackage
